// ==== design/dac_pll_test_pkg.sv ====
package dac_pll_test_pkg;

    // Bus geometry
    localparam int ADDR_W   = 12;
    localparam int DATA_W   = 32;
    localparam int STRB_W   = 4;
    localparam int REG_W    = 8;
    localparam int IDX_W    = 10;
    localparam int IDX_LSB  = 2;
    localparam int NUM_REGS = 7;
    localparam int AMP_W    = 7;
    localparam int BAND_W   = 9;
    localparam int DELAY_W  = 2;
    localparam int NIB_W    = 4;

    typedef logic [REG_W-1:0] byte_t;
    typedef logic [IDX_W-1:0] index_t;

    // Register numbers inside the bank
    localparam int SEL_POWER = 0;
    localparam int SEL_PFD   = 1;
    localparam int SEL_AMP   = 2;
    localparam int SEL_BLOW  = 3;
    localparam int SEL_BAND  = 4;
    localparam int SEL_SWEEP = 5;
    localparam int SEL_MACH  = 6;

    // Register indices; byte address is four times the index
    localparam index_t IDX_POWER_OVERRIDE = 10'h1b0;
    localparam index_t IDX_PHASE_DETECTOR = 10'h1b1;
    localparam index_t IDX_AMPLITUDE_WORD = 10'h1b2;
    localparam index_t IDX_FORCED_BAND_LO = 10'h1b3;
    localparam index_t IDX_BAND_FORCE_CAL = 10'h1b4;
    localparam index_t IDX_SWEEP_START    = 10'h1b5;
    localparam index_t IDX_MACHINE_CTRL   = 10'h1b9;

    localparam index_t REG_INDEX [NUM_REGS] = '{
        IDX_POWER_OVERRIDE, IDX_PHASE_DETECTOR, IDX_AMPLITUDE_WORD,
        IDX_FORCED_BAND_LO, IDX_BAND_FORCE_CAL, IDX_SWEEP_START, IDX_MACHINE_CTRL};
    localparam byte_t REG_RESET [NUM_REGS] = '{
        8'hfa, 8'h04, 8'h00, 8'h00, 8'h78, 8'h80, 8'h20};
    localparam byte_t REG_WMASK [NUM_REGS] = '{
        8'hfa, 8'h0e, 8'hff, 8'hff, 8'hfb, 8'hf0, 8'h20};
    localparam byte_t REG_RMASK [NUM_REGS] = '{
        8'hfa, 8'h0e, 8'h80, 8'h00, 8'hfa, 8'hf0, 8'h20};

    // Field positions
    localparam int BIT_OSC_CORE   = 7;
    localparam int BIT_OSC_BIAS   = 6;
    localparam int BIT_OSC_LEVEL  = 5;
    localparam int BIT_SYNTH      = 4;
    localparam int BIT_REGULATOR  = 3;
    localparam int BIT_CLOCK_GEN  = 1;
    localparam int PHASE_DETECTOR_DELAY_LSB  = 2;
    localparam int BIT_PHASE_DETECTOR_EDGE_SELECT   = 1;
    localparam int BIT_AMP_FORCE  = 7;
    localparam int BIT_LOAD_BYP   = 7;
    localparam int CAL_OFFSET_LSB = 3;
    localparam int BIT_BAND_FORCE = 1;
    localparam int BIT_BAND_TOP   = 0;
    localparam int SWEEP_LSB      = 4;
    localparam int BIT_MACHINE_EN = 5;

    // Power-down state after reset
    localparam logic PD_RESET = 1'h1;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : dac_pll_test_pkg

// ==== design/override_select.sv ====
`timescale 1ns/10ps
module override_select #(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         sys_rst,
    // Selection
    input  wire logic         forceEn,
    input  wire logic [W-1:0] forcedVal,
    input  wire logic [W-1:0] autoVal,
    // Applied value
    output logic      [W-1:0] applied
);
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            applied <= RST_VAL;
        end else begin
            applied <= forceEn ? forcedVal : autoVal;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_select_follows: assert property (
        !$past(sys_rst) |-> applied == ($past(forceEn) ? $past(forcedVal) : $past(autoVal)))
        else $error("override output does not follow its selection");
endmodule : override_select

// ==== design/axil_write_join.sv ====
`timescale 1ns/10ps
module axil_write_join
    import dac_pll_test_pkg::*;
(
    // Clock and reset
    input  wire logic                            clk,
    input  wire logic                            sys_rst,
    // Write address and data channels
    input  wire logic                            awvalid,
    output logic                                 awready,
    input  wire logic [dac_pll_test_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                            wvalid,
    output logic                                 wready,
    input  wire logic [dac_pll_test_pkg::DATA_W-1:0] wdata,
    input  wire logic [dac_pll_test_pkg::STRB_W-1:0] wstrb,
    // Joined write
    input  wire logic                            respBusy,
    output logic                                 wrFire,
    output logic [dac_pll_test_pkg::ADDR_W-1:0]  wrAddr,
    output logic [dac_pll_test_pkg::DATA_W-1:0]  wrData,
    output logic [dac_pll_test_pkg::STRB_W-1:0]  wrStrb
);
    import dac_pll_test_pkg::*;

    assign wrFire = !awready && !wready && !respBusy;

    // Address side
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            awready <= 1'h1;
            wrAddr  <= '0;
        end else if (awvalid && awready) begin
            awready <= 1'h0;
            wrAddr  <= awaddr;
        end else if (wrFire) begin
            awready <= 1'h1;
        end
    end

    // Data side
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wready <= 1'h1;
            wrData <= '0;
            wrStrb <= '0;
        end else if (wvalid && wready) begin
            wready <= 1'h0;
            wrData <= wdata;
            wrStrb <= wstrb;
        end else if (wrFire) begin
            wready <= 1'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_join_once: assert property (wrFire |=> awready && wready && !wrFire)
        else $error("joined write not released after firing");
endmodule : axil_write_join

// ==== design/dac_pll_test_control_regs.sv ====
// Notes on behaviour
// - Manual mode: bit 7 powers VCO down.
// - Manual mode: bit 6 powers bias down.
// - Manual mode: bit 5 powers level loop down.
// - Manual mode: bit 4 powers synthesizer down.
// - Manual mode: bit 3 powers regulator down.
// - Manual mode: bit 1 powers clock generator down.
// - Amplitude force bit selects written word.
// - Band force bit selects written band.
// - Forced band is low byte plus top bit.
// - Bits 6:3 give calibration start offset.
// - Bits 7:4 give amplitude sweep start.
// - Machine enable, reset one, blocks manual bits.
`timescale 1ns/10ps
module dac_pll_test_control_regs
    import dac_pll_test_pkg::*;
(
    // Clock and reset
    input  wire logic                                clk,
    input  wire logic                                sys_rst,
    // AXI4-Lite write address
    input  wire logic                                awvalid,
    output logic                                     awready,
    input  wire logic [dac_pll_test_pkg::ADDR_W-1:0] awaddr,
    // AXI4-Lite write data
    input  wire logic                                wvalid,
    output logic                                     wready,
    input  wire logic [dac_pll_test_pkg::DATA_W-1:0] wdata,
    input  wire logic [dac_pll_test_pkg::STRB_W-1:0] wstrb,
    // AXI4-Lite write response
    output logic                                     bvalid,
    input  wire logic                                bready,
    output logic [1:0]                               bresp,
    // AXI4-Lite read address
    input  wire logic                                arvalid,
    output logic                                     arready,
    input  wire logic [dac_pll_test_pkg::ADDR_W-1:0] araddr,
    // AXI4-Lite read data
    output logic                                     rvalid,
    input  wire logic                                rready,
    output logic [dac_pll_test_pkg::DATA_W-1:0]      rdata,
    output logic [1:0]                               rresp,
    // Requests from the automatic power machine
    input  wire logic                                autoOscCorePowerdown,
    input  wire logic                                autoOscBiasPowerdown,
    input  wire logic                                autoOscLevelLoopPowerdown,
    input  wire logic                                autoSynthesizerPowerdown,
    input  wire logic                                autoRegulatorPowerdown,
    input  wire logic                                autoClockGeneratorPowerdown,
    // Calibration results
    input  wire logic [dac_pll_test_pkg::AMP_W-1:0]  autoAmplitudeWord,
    input  wire logic [dac_pll_test_pkg::BAND_W-1:0] autoTuningBand,
    // Applied power-down controls
    output logic                                     oscCorePowerdown,
    output logic                                     oscBiasPowerdown,
    output logic                                     oscLevelLoopPowerdown,
    output logic                                     synthesizerPowerdown,
    output logic                                     regulatorPowerdown,
    output logic                                     clockGeneratorPowerdown,
    // Loop and calibration controls
    output logic                                     powerMachineEnable,
    output logic [dac_pll_test_pkg::DELAY_W-1:0]     phaseDetectorDelay,
    output logic                                     phaseDetectorEdgeSelect,
    output logic                                     loadDelayBypass,
    output logic [dac_pll_test_pkg::AMP_W-1:0]       appliedAmplitudeWord,
    output logic [dac_pll_test_pkg::BAND_W-1:0]      appliedTuningBand,
    output logic [dac_pll_test_pkg::NIB_W-1:0]       oscCalStartOffset,
    output logic [dac_pll_test_pkg::NIB_W-1:0]       amplitudeSweepStartValue
);
    import dac_pll_test_pkg::*;

    byte_t                regFile [NUM_REGS];
    logic                 wrFire;
    logic [ADDR_W-1:0]    wrAddr;
    logic [DATA_W-1:0]    wrData;
    logic [STRB_W-1:0]    wrStrb;
    logic                 wrHit;
    logic [2:0]           wrSel;
    logic                 rdHit;
    logic [2:0]           rdSel;
    logic                 manualMode;
    logic [BAND_W-1:0]    forcedBand;

    // Write address and data join
    axil_write_join u_write_join (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .awvalid  (awvalid),
        .awready  (awready),
        .awaddr   (awaddr),
        .wvalid   (wvalid),
        .wready   (wready),
        .wdata    (wdata),
        .wstrb    (wstrb),
        .respBusy (bvalid),
        .wrFire   (wrFire),
        .wrAddr   (wrAddr),
        .wrData   (wrData),
        .wrStrb   (wrStrb)
    );

    // Address decode, word aligned
    always_comb begin
        wrHit = 1'h0;
        wrSel = 3'h0;
        rdHit = 1'h0;
        rdSel = 3'h0;
        for (int i = 0; i < NUM_REGS; i++) begin
            if (wrAddr[IDX_LSB +: IDX_W] == REG_INDEX[i]) begin
                wrHit = 1'h1;
                wrSel = 3'(i);
            end
            if (araddr[IDX_LSB +: IDX_W] == REG_INDEX[i]) begin
                rdHit = 1'h1;
                rdSel = 3'(i);
            end
        end
    end

    // Register storage, low byte lane only
    // Reserved bits never stored
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regFile[i] <= REG_RESET[i];
            end
        end else if (wrFire && wrHit && wrStrb[0]) begin
            regFile[wrSel] <= (regFile[wrSel] & ~REG_WMASK[wrSel])
                            | (wrData[REG_W-1:0] & REG_WMASK[wrSel]);
        end
    end

    // Write response
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bvalid <= 1'h0;
            bresp  <= RESP_OKAY;
        end else if (wrFire) begin
            bvalid <= 1'h1;
            bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid && bready) begin
            bvalid <= 1'h0;
        end
    end

    // Read channel
    // Masked readback hides reserved bits
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            arready <= 1'h1;
            rvalid  <= 1'h0;
            rdata   <= '0;
            rresp   <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'h0;
            rvalid  <= 1'h1;
            rdata   <= '0;
            rresp   <= rdHit ? RESP_OKAY : RESP_SLVERR;
            if (rdHit) begin
                rdata[REG_W-1:0] <= regFile[rdSel] & REG_RMASK[rdSel];
            end
        end else if (rvalid && rready) begin
            rvalid  <= 1'h0;
            arready <= 1'h1;
        end
    end

    // Manual bits act only with machine off
    assign manualMode         = !regFile[SEL_MACH][BIT_MACHINE_EN];
    assign powerMachineEnable = regFile[SEL_MACH][BIT_MACHINE_EN];

    override_select #(.W(1), .RST_VAL(PD_RESET)) u_pd_core (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .forceEn   (manualMode),
        .forcedVal (regFile[SEL_POWER][BIT_OSC_CORE]),
        .autoVal   (autoOscCorePowerdown),
        .applied   (oscCorePowerdown)
    );

    override_select #(.W(1), .RST_VAL(PD_RESET)) u_pd_bias (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .forceEn   (manualMode),
        .forcedVal (regFile[SEL_POWER][BIT_OSC_BIAS]),
        .autoVal   (autoOscBiasPowerdown),
        .applied   (oscBiasPowerdown)
    );

    override_select #(.W(1), .RST_VAL(PD_RESET)) u_pd_level (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .forceEn   (manualMode),
        .forcedVal (regFile[SEL_POWER][BIT_OSC_LEVEL]),
        .autoVal   (autoOscLevelLoopPowerdown),
        .applied   (oscLevelLoopPowerdown)
    );

    override_select #(.W(1), .RST_VAL(PD_RESET)) u_pd_synth (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .forceEn   (manualMode),
        .forcedVal (regFile[SEL_POWER][BIT_SYNTH]),
        .autoVal   (autoSynthesizerPowerdown),
        .applied   (synthesizerPowerdown)
    );

    override_select #(.W(1), .RST_VAL(PD_RESET)) u_pd_regulator (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .forceEn   (manualMode),
        .forcedVal (regFile[SEL_POWER][BIT_REGULATOR]),
        .autoVal   (autoRegulatorPowerdown),
        .applied   (regulatorPowerdown)
    );

    override_select #(.W(1), .RST_VAL(PD_RESET)) u_pd_clock_gen (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .forceEn   (manualMode),
        .forcedVal (regFile[SEL_POWER][BIT_CLOCK_GEN]),
        .autoVal   (autoClockGeneratorPowerdown),
        .applied   (clockGeneratorPowerdown)
    );

    override_select #(.W(AMP_W), .RST_VAL('0)) u_amp_word (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .forceEn   (regFile[SEL_AMP][BIT_AMP_FORCE]),
        .forcedVal (regFile[SEL_AMP][AMP_W-1:0]),
        .autoVal   (autoAmplitudeWord),
        .applied   (appliedAmplitudeWord)
    );

    // Band from low byte and top bit
    assign forcedBand = {regFile[SEL_BAND][BIT_BAND_TOP], regFile[SEL_BLOW]};

    override_select #(.W(BAND_W), .RST_VAL('0)) u_band (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .forceEn   (regFile[SEL_BAND][BIT_BAND_FORCE]),
        .forcedVal (forcedBand),
        .autoVal   (autoTuningBand),
        .applied   (appliedTuningBand)
    );

    // Direct register fields
    assign phaseDetectorDelay      = regFile[SEL_PFD][PHASE_DETECTOR_DELAY_LSB +: DELAY_W];
    assign phaseDetectorEdgeSelect = regFile[SEL_PFD][BIT_PHASE_DETECTOR_EDGE_SELECT];
    assign loadDelayBypass         = regFile[SEL_BAND][BIT_LOAD_BYP];
    assign oscCalStartOffset       = regFile[SEL_BAND][CAL_OFFSET_LSB +: NIB_W];
    assign amplitudeSweepStartValue = regFile[SEL_SWEEP][SWEEP_LSB +: NIB_W];

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_manual_two;
        manualMode [*2];
    endsequence

    sequence s_read_taken;
        arvalid && arready ##1 rvalid;
    endsequence

    sequence s_write_fired;
        wrFire ##1 bvalid;
    endsequence

    a_core_manual: assert property (
        s_manual_two |-> oscCorePowerdown == $past(regFile[SEL_POWER][BIT_OSC_CORE]))
        else $error("VCO power-down does not follow its manual bit");

    a_bias_manual: assert property (
        s_manual_two |-> oscBiasPowerdown == $past(regFile[SEL_POWER][BIT_OSC_BIAS]))
        else $error("bias power-down does not follow its manual bit");

    a_level_manual: assert property (
        s_manual_two |-> oscLevelLoopPowerdown == $past(regFile[SEL_POWER][BIT_OSC_LEVEL]))
        else $error("level loop power-down does not follow its manual bit");

    a_synth_manual: assert property (
        s_manual_two |-> synthesizerPowerdown == $past(regFile[SEL_POWER][BIT_SYNTH]))
        else $error("synthesizer power-down does not follow its manual bit");

    a_ldo_manual: assert property (
        s_manual_two |-> regulatorPowerdown == $past(regFile[SEL_POWER][BIT_REGULATOR]))
        else $error("regulator power-down does not follow its manual bit");

    a_clkgen_manual: assert property (
        s_manual_two |-> clockGeneratorPowerdown == $past(regFile[SEL_POWER][BIT_CLOCK_GEN]))
        else $error("clock generator power-down does not follow its manual bit");

    a_machine_auto: assert property (
        $past(!manualMode) && !$past(sys_rst)
        |-> oscCorePowerdown == $past(autoOscCorePowerdown)
            && synthesizerPowerdown == $past(autoSynthesizerPowerdown))
        else $error("manual bits act while the power machine is on");

    a_amp_forced: assert property (
        $past(regFile[SEL_AMP][BIT_AMP_FORCE]) && !$past(sys_rst)
        |-> appliedAmplitudeWord == $past(regFile[SEL_AMP][AMP_W-1:0]))
        else $error("forced amplitude word not applied");

    a_band_forced: assert property (
        $past(regFile[SEL_BAND][BIT_BAND_FORCE]) && !$past(sys_rst)
        |-> appliedTuningBand == $past(forcedBand))
        else $error("forced tuning band not applied");

    a_band_top_bit: assert property (
        $past(regFile[SEL_BAND][BIT_BAND_FORCE]) && !$past(sys_rst)
        |-> appliedTuningBand[BAND_W-1] == $past(regFile[SEL_BAND][BIT_BAND_TOP])
            && appliedTuningBand[REG_W-1:0] == $past(regFile[SEL_BLOW]))
        else $error("forced band assembled wrongly");

    a_cal_offset: assert property (
        $rose(!sys_rst)
        |-> oscCalStartOffset == REG_RESET[SEL_BAND][CAL_OFFSET_LSB +: NIB_W])
        else $error("calibration offset reset value wrong");

    a_sweep_write: assert property (
        wrFire && wrHit && wrSel == 3'(SEL_SWEEP) && wrStrb[0]
        |=> amplitudeSweepStartValue == $past(wrData[SWEEP_LSB +: NIB_W]))
        else $error("sweep start value not written");

    a_reserved_zero: assert property (
        s_read_taken |-> rdata[DATA_W-1:REG_W] == '0
        && ($past(rdSel) != 3'(SEL_POWER)
            || (rdata[REG_W-1:0] & ~REG_WMASK[SEL_POWER]) == '0))
        else $error("reserved bits read as nonzero");

    a_write_resp: assert property (
        s_write_fired |-> bresp == ($past(wrHit) ? RESP_OKAY : RESP_SLVERR))
        else $error("write response code wrong");

    a_read_hold: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped before taken");
endmodule : dac_pll_test_control_regs

// ==== verif/dac_pll_test_control_regs_tb_top.sv ====
`timescale 1ns/10ps
module dac_pll_test_control_regs_tb_top;
    import dac_pll_test_pkg::*;
    localparam byte_t RST [NUM_REGS] = '{8'hfa, 8'h04, 8'h00, 8'h00, 8'h78, 8'h80, 8'h20};
    logic              clk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
    wire               awready, wready, bvalid, arready, rvalid;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, d, wd, r;
    wire  [DATA_W-1:0] rdata;
    logic [STRB_W-1:0] wstrb;
    wire  [1:0]        bresp, rresp;
    logic [1:0]        resp;
    logic [5:0]        autoPd;
    wire  [5:0]        pd;
    logic [AMP_W-1:0]  autoAmp;
    wire  [AMP_W-1:0]  amp;
    logic [BAND_W-1:0] autoBand;
    wire  [BAND_W-1:0] band;
    wire               mach, edgeSel, bypass;
    wire  [DELAY_W-1:0] delay;
    wire  [NIB_W-1:0]  calOff, sweep;
    int                failures, cmp_count, seed, sel;
    byte_t             regv [NUM_REGS];

    dac_pll_test_control_regs i_dut (
        .clk, .sys_rst, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
        .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
        .autoOscCorePowerdown(autoPd[5]), .autoOscBiasPowerdown(autoPd[4]),
        .autoOscLevelLoopPowerdown(autoPd[3]), .autoSynthesizerPowerdown(autoPd[2]),
        .autoRegulatorPowerdown(autoPd[1]), .autoClockGeneratorPowerdown(autoPd[0]),
        .autoAmplitudeWord(autoAmp), .autoTuningBand(autoBand),
        .oscCorePowerdown(pd[5]), .oscBiasPowerdown(pd[4]), .oscLevelLoopPowerdown(pd[3]),
        .synthesizerPowerdown(pd[2]), .regulatorPowerdown(pd[1]), .clockGeneratorPowerdown(pd[0]),
        .powerMachineEnable(mach), .phaseDetectorDelay(delay), .phaseDetectorEdgeSelect(edgeSel),
        .loadDelayBypass(bypass), .appliedAmplitudeWord(amp), .appliedTuningBand(band),
        .oscCalStartOffset(calOff), .amplitudeSweepStartValue(sweep));

    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic hang;
        failures++;
        report_and_stop();
    endtask : hang

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] dd, input logic [3:0] s);
        bit pa;
        bit pw;
        int k;
        @(posedge clk);
        awvalid <= 1;
        wvalid <= 1;
        awaddr <= a;
        wdata <= dd;
        wstrb <= s;
        bready <= 1;
        pa = 1;
        pw = 1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (pa && awready) begin
                awvalid <= 0;
                pa = 0;
            end
            if (pw && wready) begin
                wvalid <= 0;
                pw = 0;
            end
            if (bvalid) break;
        end
        resp = bresp;
        bready <= 0;
        if (k >= 50) hang();
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a);
        bit pa;
        int k;
        @(posedge clk);
        arvalid <= 1;
        araddr <= a;
        rready <= 1;
        pa = 1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (pa && arready) begin
                arvalid <= 0;
                pa = 0;
            end
            if (rvalid) break;
        end
        d = rdata;
        resp = rresp;
        rready <= 0;
        if (k >= 50) hang();
    endtask : rd

    // Outputs against the register model and the automatic inputs
    task automatic chk_out;
        byte_t p;
        logic m;
        repeat (3) @(posedge clk);
        p = regv[SEL_POWER];
        m = regv[SEL_MACH][5];
        chk("enable", m, mach);
        chk("powerdown", m ? autoPd : {p[7], p[6], p[5], p[4], p[3], p[1]}, pd);
        chk("amplitude", regv[SEL_AMP][7] ? regv[SEL_AMP][6:0] : autoAmp, amp);
        chk("band", regv[SEL_BAND][1] ? {regv[SEL_BAND][0], regv[SEL_BLOW]} : autoBand, band);
        chk("cal offset", {regv[SEL_BAND][7], regv[SEL_BAND][6:3]}, {bypass, calOff});
        chk("sweep", regv[SEL_SWEEP][7:4], sweep);
        chk("phase det", regv[SEL_PFD][3:1], {delay, edgeSel});
    endtask : chk_out

    task automatic rd_chk(input int i);
        rd({REG_INDEX[i], 2'b00});
        chk("readback", regv[i] & REG_RMASK[i], d);
        chk("rresp", RESP_OKAY, resp);
    endtask : rd_chk

    initial begin
        {sys_rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {awaddr, araddr, wdata, wstrb} = '0;
        seed = 37;
        r = $random(seed);
        {autoPd, autoAmp, autoBand} = r[21:0];
        regv = RST;
        repeat (16) @(posedge clk);
        sys_rst <= 0;
        for (int i = 0; i < NUM_REGS; i++) rd_chk(i);
        chk_out();
        // Random writes to every register, machine enable and force bits toggled
        for (int it = 0; it < 28; it++) begin
            sel = it % NUM_REGS;
            wd = $random(seed);
            if (sel == SEL_MACH) wd[BIT_MACHINE_EN] = 1'((it / NUM_REGS) % 2);
            if (sel == SEL_AMP) wd[BIT_AMP_FORCE] = it[0];
            if (sel == SEL_BAND) wd[BIT_BAND_FORCE] = it[0];
            wr({REG_INDEX[sel], 2'b00}, wd, 4'hf);
            chk("bresp", RESP_OKAY, resp);
            regv[sel] = wd[7:0] & REG_WMASK[sel];
            r = $random(seed);
            autoPd <= r[5:0];
            autoAmp <= r[12:6];
            autoBand <= r[21:13];
            chk_out();
            rd_chk(sel);
        end
        // Byte lane zero off leaves the register alone
        wr({REG_INDEX[SEL_PFD], 2'b00}, 32'hffff_ffff, 4'he);
        chk("bresp", RESP_OKAY, resp);
        rd_chk(SEL_PFD);
        // Unmapped index in the gap
        wr(12'h6d8, 32'hffff_ffff, 4'hf);
        chk("bresp", RESP_SLVERR, resp);
        rd(12'h6d8);
        chk("rdata", 32'h0, d);
        chk("rresp", RESP_SLVERR, resp);
        chk_out();
        // Reset in mid-run restores every field
        sys_rst <= 1;
        repeat (2) @(posedge clk);
        chk("reset powerdown", 6'h3f, pd);
        chk("reset amplitude", 7'h0, amp);
        chk("reset band", 9'h0, band);
        sys_rst <= 0;
        regv = RST;
        for (int i = 0; i < NUM_REGS; i++) rd_chk(i);
        chk_out();
        report_and_stop();
    end
endmodule : dac_pll_test_control_regs_tb_top
